// ===== logic/subchannel_bit_processor.sv
// Chosen here: the register addresses and strobed register access.
module subchannel_bit_processor
   import subch_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic frame_tick,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [N_FIFO*8-1:0] tx_fifo_data,
   output logic [N_FIFO-1:0] tx_fifo_take,
   output logic [N_FIFO*8-1:0] tx_slot_byte,
   output logic tx_slot_valid,
   input wire logic [N_FIFO*8-1:0] rx_slot_byte,
   output logic [N_FIFO*8-1:0] rx_fifo_data,
   output logic [N_FIFO*4-1:0] rx_fifo_bits,
   output logic [N_FIFO-1:0] rx_fifo_valid
);
   // ************************************
   // register file
   // ************************************
   logic [CFG_W-1:0] tx_cfg [N_FIFO];
   logic [CFG_W-1:0] rx_cfg [N_FIFO];
   logic [7:0] fill_mask [N_FIFO];
   logic [CFG_W-1:0] next_tx_cfg [N_FIFO];
   logic [CFG_W-1:0] next_rx_cfg [N_FIFO];
   logic [7:0] next_fill_mask [N_FIFO];
   logic [IDX_W-1:0] sel_num, next_sel_num;
   logic sel_rx, next_sel_rx;
   map_mode_t map_mode, next_map_mode;
   logic [7:0] frame_count, next_frame_count;
   logic [31:0] next_reg_rdata;
   logic single;

   assign single = (map_mode == single_map_mode);

   // ************************************
   // part A per fifo
   // ************************************
   logic [7:0] rx_in [N_FIFO];
   logic [N_FIFO-1:0] rx_active, tx_active;
   logic [7:0] tx_field [N_FIFO];
   logic [7:0] tx_sel [N_FIFO];

   always_comb
   begin
      for (int f = 0; f < N_FIFO; f++)
      begin
         if (single)
         begin
            rx_in[f] = rx_slot_byte[f*8 +: 8];
            rx_active[f] = 1'b1;
            tx_active[f] = 1'b1;
         end
         else
         begin
            // same unmodified byte to all assigners on the slot
            rx_in[f] = rx_slot_byte[32'(rx_cfg[f][CFG_SLOT_LSB +: IDX_W])*8 +: 8];
            rx_active[f] = rx_cfg[f][CFG_CONNECT_BIT];
            tx_active[f] = tx_cfg[f][CFG_CONNECT_BIT];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < N_FIFO; g++)
      begin : g_part_a
         subchannel_part_a u_part_a (
            .clk(clk),
            .arst_n(arst_n),
            .frame_tick(frame_tick),
            .active(rx_active[g]),
            .rx_cfg(rx_cfg[g]),
            .tx_cfg(tx_cfg[g]),
            .rx_byte(rx_in[g]),
            .tx_fifo_byte(tx_fifo_data[g*8 +: 8]),
            .rx_data(rx_fifo_data[g*8 +: 8]),
            .rx_bits(rx_fifo_bits[g*4 +: 4]),
            .rx_valid(rx_fifo_valid[g]),
            .tx_field(tx_field[g]),
            .tx_sel(tx_sel[g])
         );
      end
   endgenerate

   // ************************************
   // part B transmit merge
   // ************************************
   logic [7:0] merged [N_FIFO];
   logic [N_FIFO*8-1:0] next_tx_slot_byte;
   logic next_tx_slot_valid;
   logic [N_FIFO-1:0] next_tx_fifo_take;

   always_comb
   begin
      for (int s = 0; s < N_FIFO; s++)
      begin
         merged[s] = fill_mask[s];
         for (int f = 0; f < N_FIFO; f++)
         begin
            // later fifos win where fields overlap
            if ((single && f == s) || (!single && tx_active[f]
                && 32'(tx_cfg[f][CFG_SLOT_LSB +: IDX_W]) == s))
            begin
               merged[s] = (merged[s] & ~tx_sel[f]) | tx_field[f];
            end
         end
      end
   end

   always_comb
   begin
      next_tx_slot_valid = frame_tick;
      next_tx_fifo_take = frame_tick ? tx_active : '0;
      next_tx_slot_byte = tx_slot_byte;
      if (frame_tick)
      begin
         for (int s = 0; s < N_FIFO; s++)
         begin
            next_tx_slot_byte[s*8 +: 8] = merged[s];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_slot_byte <= '0;
         tx_slot_valid <= 1'b0;
         tx_fifo_take <= '0;
      end
      else
      begin
         tx_slot_byte <= next_tx_slot_byte;
         tx_slot_valid <= next_tx_slot_valid;
         tx_fifo_take <= next_tx_fifo_take;
      end
   end

   // ************************************
   // register access
   // ************************************
   always_comb
   begin
      next_tx_cfg = tx_cfg;
      next_rx_cfg = rx_cfg;
      next_fill_mask = fill_mask;
      next_sel_num = sel_num;
      next_sel_rx = sel_rx;
      next_map_mode = map_mode;
      next_frame_count = frame_tick ? frame_count + 8'h01 : frame_count;
      next_reg_rdata = 32'h0000_0000;
      if (frame_tick)
      begin
         for (int s = 0; s < N_FIFO; s++)
         begin
            next_fill_mask[s] = merged[s];
         end
      end
      if (reg_wr)
      begin
         case (reg_addr)
            OFF_INDEX:
            begin
               next_sel_num = reg_wdata[IDX_NUM_LSB +: IDX_W];
               next_sel_rx = reg_wdata[IDX_DIR_BIT];
            end
            OFF_CONFIG:
            begin
               if (sel_rx)
               begin
                  next_rx_cfg[sel_num] = reg_wdata[CFG_W-1:0];
               end
               else
               begin
                  next_tx_cfg[sel_num] = reg_wdata[CFG_W-1:0];
               end
            end
            OFF_MASK:
            begin
               // mask exists for transmit slots only
               if (!sel_rx)
               begin
                  next_fill_mask[sel_num] = reg_wdata[7:0];
               end
            end
            OFF_MODE:
            begin
               if (reg_wdata[1:0] == 2'(channel_select_mapping))
               begin
                  next_map_mode = channel_select_mapping;
               end
               else if (reg_wdata[1:0] == 2'(fifo_sequence_mapping))
               begin
                  next_map_mode = fifo_sequence_mapping;
               end
               else
               begin
                  next_map_mode = single_map_mode;
               end
            end
            default:
            begin
               next_map_mode = map_mode;
            end
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            OFF_INDEX:
            begin
               next_reg_rdata[IDX_NUM_LSB +: IDX_W] = sel_num;
               next_reg_rdata[IDX_DIR_BIT] = sel_rx;
            end
            OFF_CONFIG:
            begin
               next_reg_rdata[CFG_W-1:0] = sel_rx ? rx_cfg[sel_num] : tx_cfg[sel_num];
            end
            OFF_MASK:
            begin
               next_reg_rdata[7:0] = sel_rx ? 8'h00 : fill_mask[sel_num];
            end
            OFF_MODE:
            begin
               next_reg_rdata[1:0] = map_mode;
            end
            OFF_STATUS:
            begin
               next_reg_rdata[7:0] = frame_count;
            end
            default:
            begin
               next_reg_rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int f = 0; f < N_FIFO; f++)
         begin
            tx_cfg[f] <= CFG_RESET;
            rx_cfg[f] <= CFG_RESET;
            fill_mask[f] <= MASK_RESET;
         end
         sel_num <= '0;
         sel_rx <= 1'b0;
         map_mode <= single_map_mode;
         frame_count <= 8'h00;
         reg_rdata <= 32'h0000_0000;
      end
      else
      begin
         tx_cfg <= next_tx_cfg;
         rx_cfg <= next_rx_cfg;
         fill_mask <= next_fill_mask;
         sel_num <= next_sel_num;
         sel_rx <= next_sel_rx;
         map_mode <= next_map_mode;
         frame_count <= next_frame_count;
         reg_rdata <= next_reg_rdata;
      end
   end

   // ************************************
   // assertions
   // ************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   AST_TX_ON_TICK: assert property (frame_tick |=> tx_slot_valid)
      else $error("slot byte not sent after frame tick");
   AST_TX_ONLY_TICK: assert property (tx_slot_valid |-> $past(frame_tick))
      else $error("slot byte sent without frame tick");
   AST_RX_ONE_PER_FRAME: assert property (rx_fifo_valid[0] |-> $past(frame_tick))
      else $error("receive byte outside frame tick");
   AST_RX_SHIFT: assert property (frame_tick && single && rx_cfg[0][CFG_BYPASS_BIT]
      |=> rx_fifo_data[7:0] == ($past(rx_slot_byte[7:0])
      >> $past(rx_cfg[0][CFG_START_LSB +: 3])))
      else $error("transparent receive field not at bit zero");
   AST_RX_FULL_BYTE: assert property (rx_fifo_valid[0] && $past(rx_cfg[0][CFG_BYPASS_BIT])
      |-> rx_fifo_bits[3:0] == BYTE_BITS)
      else $error("transparent receive not a full byte");
   AST_RX_HDLC_BITS: assert property (rx_fifo_valid[0] && !$past(rx_cfg[0][CFG_BYPASS_BIT])
      |-> rx_fifo_bits[3:0] == (($past(rx_cfg[0][2:0]) == 3'd0) ? BYTE_BITS
      : {1'b0, $past(rx_cfg[0][2:0])}))
      else $error("framed receive bit count wrong");
   AST_TX_FIELD: assert property (frame_tick && single
      |=> (tx_slot_byte[7:0] & $past(tx_sel[0])) == $past(tx_field[0]))
      else $error("transmit field not inserted");
   AST_TX_MASK_REST: assert property (frame_tick && single
      |=> (tx_slot_byte[7:0] & ~$past(tx_sel[0]))
      == ($past(fill_mask[0]) & ~$past(tx_sel[0])))
      else $error("mask bits outside field changed");
   AST_MASK_KEEPS_OUTPUT: assert property (frame_tick && !reg_wr
      |=> fill_mask[0] == tx_slot_byte[7:0])
      else $error("mask does not hold processed byte");

   COV_SINGLE: cover property (frame_tick && single);
   COV_MULTI: cover property (frame_tick && !single && tx_active[0] && tx_active[1]);
   COV_HDLC_RX: cover property (rx_fifo_valid[0] && rx_fifo_bits[3:0] != BYTE_BITS);
endmodule // subchannel_bit_processor

// ===== logic/subch_pkg.sv
package subch_pkg;
   localparam int N_FIFO = 4;
   localparam int IDX_W = 2;
   localparam int ADDR_W = 5;
   // register byte addresses
   localparam logic [4:0] OFF_INDEX = 5'h00;
   localparam logic [4:0] OFF_CONFIG = 5'h04;
   localparam logic [4:0] OFF_MASK = 5'h08;
   localparam logic [4:0] OFF_MODE = 5'h0c;
   localparam logic [4:0] OFF_STATUS = 5'h10;
   // fifo_index_select fields
   localparam int IDX_NUM_LSB = 0;
   localparam int IDX_DIR_BIT = 4;
   // subchannel_config fields
   localparam int CFG_W = 10;
   localparam int CFG_CNT_LSB = 0;
   localparam int CFG_START_LSB = 3;
   localparam int CFG_BYPASS_BIT = 6;
   localparam int CFG_CONNECT_BIT = 7;
   localparam int CFG_SLOT_LSB = 8;
   localparam logic [9:0] CFG_RESET = 10'h040;
   localparam logic [7:0] MASK_RESET = 8'hff;
   localparam logic [7:0] FULL_BYTE = 8'hff;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   typedef enum logic [1:0] {
      single_map_mode,
      channel_select_mapping,
      fifo_sequence_mapping
   } map_mode_t;
endpackage

// ===== logic/subchannel_part_a.sv
module subchannel_part_a
   import subch_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic frame_tick,
   input wire logic active,
   input wire logic [CFG_W-1:0] rx_cfg,
   input wire logic [CFG_W-1:0] tx_cfg,
   input wire logic [7:0] rx_byte,
   input wire logic [7:0] tx_fifo_byte,
   output logic [7:0] rx_data,
   output logic [3:0] rx_bits,
   output logic rx_valid,
   output logic [7:0] tx_field,
   output logic [7:0] tx_sel
);
   logic [2:0] rx_cnt, rx_start, tx_cnt, tx_start;
   logic [7:0] rx_low, tx_low;
   logic [7:0] next_rx_data;
   logic [3:0] next_rx_bits;
   logic next_rx_valid;

   assign rx_cnt = rx_cfg[CFG_CNT_LSB +: 3];
   assign rx_start = rx_cfg[CFG_START_LSB +: 3];
   assign tx_cnt = tx_cfg[CFG_CNT_LSB +: 3];
   assign tx_start = tx_cfg[CFG_START_LSB +: 3];
   // count zero means a whole byte
   assign rx_low = FULL_BYTE >> (3'd0 - rx_cnt);
   assign tx_low = FULL_BYTE >> (3'd0 - tx_cnt);

   // transmit: field at bit 0 moved up, overflow past bit 7 lost
   assign tx_sel = tx_low << tx_start;
   assign tx_field = (tx_fifo_byte & tx_low) << tx_start;

   always_comb
   begin
      next_rx_valid = frame_tick & active;
      next_rx_data = rx_data;
      next_rx_bits = rx_bits;
      if (frame_tick && active)
      begin
         if (rx_cfg[CFG_BYPASS_BIT])
         begin
            next_rx_data = rx_byte >> rx_start;
            next_rx_bits = BYTE_BITS;
         end
         else
         begin
            next_rx_data = (rx_byte >> rx_start) & rx_low;
            next_rx_bits = (rx_cnt == 3'd0) ? BYTE_BITS : {1'b0, rx_cnt};
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_data <= 8'h00;
         rx_bits <= 4'h0;
         rx_valid <= 1'b0;
      end
      else
      begin
         rx_data <= next_rx_data;
         rx_bits <= next_rx_bits;
         rx_valid <= next_rx_valid;
      end
   end
endmodule // subchannel_part_a

// ===== tb/fifo_side_model.sv
module fifo_side_model
   import subch_pkg::*;
(
   input wire logic clk,
   output logic frame_tick,
   output logic [N_FIFO*8-1:0] tx_fifo_data,
   output logic [N_FIFO*8-1:0] rx_slot_byte
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      frame_tick = 1'b0;
      tx_fifo_data = '0;
      rx_slot_byte = '0;
   end

   // one byte per fifo and per slot at each frame strobe
   task automatic send(input logic [31:0] tx, input logic [31:0] rx);
      @(posedge clk);
      frame_tick <= 1'b1;
      tx_fifo_data <= tx;
      rx_slot_byte <= rx;
      @(posedge clk);
      frame_tick <= 1'b0;
      tx_fifo_data <= ~tx;
      rx_slot_byte <= ~rx;
   endtask
endmodule // fifo_side_model

// ===== tb/subchannel_bit_processor_tb_top.sv
module subchannel_bit_processor_tb_top
   import subch_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic frame_tick;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] tx_fifo_data;
   logic [3:0] tx_fifo_take;
   logic [31:0] tx_slot_byte;
   logic tx_slot_valid;
   logic [31:0] rx_slot_byte;
   logic [31:0] rx_fifo_data;
   logic [15:0] rx_fifo_bits;
   logic [3:0] rx_fifo_valid;
   int n_fail = 0;
   int tests_run = 0;

   always #5 clk = ~clk;

   subchannel_bit_processor dut (.clk(clk), .arst_n(arst_n), .frame_tick(frame_tick),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tx_fifo_data(tx_fifo_data), .tx_fifo_take(tx_fifo_take),
      .tx_slot_byte(tx_slot_byte), .tx_slot_valid(tx_slot_valid),
      .rx_slot_byte(rx_slot_byte), .rx_fifo_data(rx_fifo_data),
      .rx_fifo_bits(rx_fifo_bits), .rx_fifo_valid(rx_fifo_valid));

   fifo_side_model model (.clk(clk), .frame_tick(frame_tick), .tx_fifo_data(tx_fifo_data),
      .rx_slot_byte(rx_slot_byte));

   // ***********************************
   // helpers
   // ***********************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string nm);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, exp, reg_rdata);
   endtask

   task automatic cfg(input logic [4:0] idx, input logic [31:0] c);
      wr(OFF_INDEX, {27'h0, idx});
      wr(OFF_CONFIG, c);
   endtask

   task automatic frame(input logic [31:0] tx, input logic [31:0] rx);
      model.send(tx, rx);
      #1;
      chk("tx_slot_valid", 32'h1, {31'h0, tx_slot_valid});
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ***********************************
   // scenarios
   // ***********************************
   task automatic test_reset();
      rd(OFF_CONFIG, 32'h040, "config reset");
      rd(OFF_MASK, 32'hff, "mask reset");
      rd(OFF_MODE, 32'h0, "mode reset");
      rd(5'h14, 32'h0, "unmapped read");
      $display("test reset done");
   endtask

   task automatic test_single_tx_rx();
      cfg(5'h01, 32'h04b);
      cfg(5'h02, 32'h073);
      cfg(5'h11, 32'h048);
      cfg(5'h12, 32'h00b);
      cfg(5'h13, 32'h010);
      wr(OFF_INDEX, 32'h01);
      wr(OFF_MASK, 32'hb0);
      wr(OFF_INDEX, 32'h02);
      wr(OFF_MASK, 32'h00);
      frame(32'h00ffff3c, 32'h0);
      chk("slot bytes f1", 32'h00c0be3c, tx_slot_byte);
      chk("take f1", 32'hf, {28'h0, tx_fifo_take});
      @(posedge clk);
      #1;
      chk("valid pulse", 32'h0, {31'h0, tx_slot_valid});
      wr(OFF_INDEX, 32'h01);
      rd(OFF_MASK, 32'hbe, "mask after frame");
      frame(32'h0005053c, 32'hf4b6b65a);
      chk("slot bytes f2", 32'h0040ba3c, tx_slot_byte);
      chk("rx data", 32'h3d035b5a, rx_fifo_data);
      chk("rx bits", 32'h8388, {16'h0, rx_fifo_bits});
      chk("rx valid", 32'hf, {28'h0, rx_fifo_valid});
      wr(OFF_INDEX, 32'h11);
      rd(OFF_CONFIG, 32'h048, "rx config");
      wr(OFF_INDEX, 32'h01);
      rd(OFF_CONFIG, 32'h04b, "tx config");
      $display("test single done");
   endtask

   task automatic test_multi();
      wr(OFF_MODE, 32'(channel_select_mapping));
      cfg(5'h00, 32'h3c4);
      cfg(5'h02, 32'h3e3);
      cfg(5'h03, 32'h3fa);
      cfg(5'h10, 32'h3c0);
      cfg(5'h12, 32'h3a3);
      wr(OFF_INDEX, 32'h03);
      wr(OFF_MASK, 32'h00);
      frame(32'h03ffffa5, 32'hd6000000);
      chk("merged slot", 32'hf540ba3c, tx_slot_byte);
      chk("take multi", 32'hd, {28'h0, tx_fifo_take});
      chk("rx shared", 32'h000500d6, rx_fifo_data & 32'h00ff00ff);
      chk("rx bits multi", 32'h0308, {16'h0, rx_fifo_bits & 16'h0f0f});
      chk("rx valid multi", 32'h5, {28'h0, rx_fifo_valid});
      rd(OFF_STATUS, 32'h3, "frame count");
      $display("test multi done");
   endtask

   task automatic test_sequence();
      wr(OFF_MODE, 32'(fifo_sequence_mapping));
      rd(OFF_MODE, 32'h2, "mode sequence");
      cfg(5'h10, 32'h392);
      frame(32'h0, 32'h5a000000);
      chk("seq slot", 32'h0040ba3c, tx_slot_byte);
      chk("seq rx", 32'h00050002, rx_fifo_data & 32'h00ff00ff);
      chk("seq rx bits", 32'h0302, {16'h0, rx_fifo_bits & 16'h0f0f});
      chk("seq rx valid", 32'h5, {28'h0, rx_fifo_valid});
      wr(OFF_MODE, 32'h3);
      rd(OFF_MODE, 32'h0, "mode three");
      $display("test sequence done");
   endtask

   initial
   begin
      #100000;
      n_fail++;
      print_verdict();
   end

   initial
   begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      test_reset();
      test_single_tx_rx();
      test_multi();
      test_sequence();
      print_verdict();
   end
endmodule // subchannel_bit_processor_tb_top
